// [core/dfsr_defines.svh]
// Named constants for the DAC feature setting register decoder.
`ifndef DFSR_DEFINES_SVH
`define DFSR_DEFINES_SVH

// Mode pin level that marks an address byte on the control port.
`define DFSR_MODE_ADDR      1'b0
// Bus address of this device in bits 7:2 of an address byte.
`define DFSR_DEV_ADDR       6'h05
`define DFSR_ADDR_MSB       7
`define DFSR_ADDR_LSB       2
`define DFSR_TYPE_MSB       1
`define DFSR_TYPE_LSB       0
`define DFSR_TYPE_DATA      2'h0
`define DFSR_TYPE_STATUS    2'h2

// Register select and value fields of a setting byte.
`define DFSR_REG_MSB        7
`define DFSR_REG_LSB        6
`define DFSR_REG_PRIMARY    2'h0
`define DFSR_REG_SECOND     2'h2
`define DFSR_REG_DEFAULT    2'h3
`define DFSR_DEFAULT_VALUE  6'h01
`define DFSR_VAL_MSB        5
`define DFSR_VAL_LSB        0
`define DFSR_RATIO_MSB      5
`define DFSR_RATIO_LSB      4
`define DFSR_IF_MSB         3
`define DFSR_IF_LSB         1
`define DFSR_DEEMPH_MSB     4
`define DFSR_DEEMPH_LSB     3
`define DFSR_MUTE_BIT       2
`define DFSR_RATIO_UNUSED   2'h3
`define DFSR_IF_LAST        3'h4

// Serial byte assembly.
`define DFSR_BIT_FIRST      3'h0
`define DFSR_BIT_STEP       3'h1
`define DFSR_BIT_LAST       3'h7

// Reset values of the settings.
`define DFSR_RST_RATIO      2'h0
`define DFSR_RST_IF         3'h0
`define DFSR_RST_VOLUME     6'h00
`define DFSR_RST_DEEMPH     2'h0
`define DFSR_RST_MUTE       1'b0

// Volume code breakpoints and attenuation figures in dB.
`define DFSR_VOL_UNITY_END  6'h01
`define DFSR_VOL_LINEAR_END 6'h32
`define DFSR_VOL_UPPER_BASE 6'h33
`define DFSR_VOL_FINITE_END 6'h3C
`define DFSR_VOL_STEP       6'h01
`define DFSR_DB_ZERO        6'h00
`define DFSR_DB_51          6'h33
`define DFSR_DB_52          6'h34
`define DFSR_DB_54          6'h36
`define DFSR_DB_57          6'h39
`define DFSR_DB_60          6'h3C

`endif

// [core/dfsr_pkg.sv]
// Types shared by the DAC feature setting register decoder.
`default_nettype none
package dfsr_pkg;

	typedef struct packed
	{
		logic [1:0] sysclk_ratio_sel;
		logic [2:0] input_format;
	} dfsr_clk_fmt_t;

	typedef struct packed
	{
		logic [1:0] deemph_sel;
		logic       mute_flag;
	} dfsr_dm_t;

	typedef struct packed
	{
		logic       is_addr;
		logic [7:0] value;
	} dfsr_byte_t;

endpackage
`default_nettype wire

// [core/dfsr_top.sv]
// Feature setting registers of a stereo DAC, loaded over the three-wire control port.
`timescale 1ns/1ps
`default_nettype none
`include "dfsr_defines.svh"

module dfsr_top
(
	input  wire logic                   clock,
	input  wire logic                   sys_rst,
	input  wire logic                   ctrl_clk,
	input  wire logic                   ctrl_mode,
	input  wire logic                   ctrl_data,
	output var  dfsr_pkg::dfsr_clk_fmt_t clk_fmt,
	output logic [5:0]                  volume_code,
	output var  dfsr_pkg::dfsr_dm_t      deemph_mute,
	output logic [5:0]                  atten_db,
	output logic                        full_atten,
	output logic                        soft_mute,
	output logic                        iface_selected
);
	import dfsr_pkg::*;

	logic [2:0]  bit_cnt;
	logic [7:0]  shift;
	logic        mode_q;
	logic        mode_break;
	dfsr_byte_t  hold;
	logic        hold_tgl;
	logic        tgl_s1;
	logic        tgl_s2;
	logic        tgl_s3;
	logic        tgl_seen;
	logic        byte_evt;
	dfsr_byte_t  cap;
	logic        cap_valid;
	logic [1:0]  xfer_type;
	logic        status_ok;
	logic        volume_wr;
	logic        dm_wr;
	logic        dflt_wr;

	// Picks a setting byte that targets the given register of the given group.
	function automatic logic targets(input dfsr_byte_t b, input logic sel,
		input logic [1:0] xfer, input logic [1:0] want_xfer, input logic [1:0] want_reg);
		targets = !b.is_addr && sel && (xfer == want_xfer)
			&& (b.value[`DFSR_REG_MSB:`DFSR_REG_LSB] == want_reg);
	endfunction

	// Maps a volume code to attenuation in dB; the upper range moves in coarse pairs.
	function automatic logic [5:0] atten_of(input logic [5:0] code);
		logic [5:0] a;
		logic [2:0] idx;
		a = `DFSR_DB_ZERO;
		idx = 3'((code - `DFSR_VOL_UPPER_BASE) >> 1);
		if (code <= `DFSR_VOL_UNITY_END)
		begin
			a = `DFSR_DB_ZERO;
		end
		else if (code <= `DFSR_VOL_LINEAR_END)
		begin
			a = code - `DFSR_VOL_STEP;
		end
		else
		begin
			case (idx)
				3'h0:    a = `DFSR_DB_51;
				3'h1:    a = `DFSR_DB_52;
				3'h2:    a = `DFSR_DB_54;
				3'h3:    a = `DFSR_DB_57;
				default: a = `DFSR_DB_60;
			endcase
		end
		atten_of = a;
	endfunction

	// A mode change in the middle of a byte drops the partial bits and starts over.
	assign mode_break = (ctrl_mode != mode_q) && (bit_cnt != `DFSR_BIT_FIRST);

	always_ff @(posedge ctrl_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			bit_cnt <= `DFSR_BIT_FIRST;
			shift <= 8'h00;
			mode_q <= `DFSR_MODE_ADDR;
		end
		else
		begin
			mode_q <= ctrl_mode;
			if (mode_break)
			begin
				shift <= {7'h00, ctrl_data};
				bit_cnt <= `DFSR_BIT_STEP;
			end
			else
			begin
				shift <= {shift[6:0], ctrl_data};
				bit_cnt <= 3'(bit_cnt + `DFSR_BIT_STEP);
			end
		end
	end

	// The held byte stays put for eight link clocks, far longer than the crossing takes.
	always_ff @(posedge ctrl_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			hold <= '0;
			hold_tgl <= 1'b0;
		end
		else if (bit_cnt == `DFSR_BIT_LAST && !mode_break)
		begin
			hold.value <= {shift[6:0], ctrl_data};
			hold.is_addr <= (ctrl_mode == `DFSR_MODE_ADDR);
			hold_tgl <= ~hold_tgl;
		end
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tgl_s1 <= 1'b0;
			tgl_s2 <= 1'b0;
			tgl_s3 <= 1'b0;
			tgl_seen <= 1'b0;
		end
		else
		begin
			tgl_s1 <= hold_tgl;
			tgl_s2 <= tgl_s1;
			tgl_s3 <= tgl_s2;
			tgl_seen <= tgl_s3;
		end
	end

	// A toggle counts only once the second and third stages agree on its new level.
	assign byte_evt = (tgl_s2 == tgl_s3) && (tgl_s3 != tgl_seen);

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cap <= '0;
			cap_valid <= 1'b0;
		end
		else
		begin
			cap_valid <= byte_evt;
			if (byte_evt)
			begin
				cap <= hold;
			end
		end
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			iface_selected <= 1'b0;
			xfer_type <= `DFSR_TYPE_DATA;
		end
		else if (cap_valid && cap.is_addr)
		begin
			iface_selected <= (cap.value[`DFSR_ADDR_MSB:`DFSR_ADDR_LSB] == `DFSR_DEV_ADDR);
			xfer_type <= cap.value[`DFSR_TYPE_MSB:`DFSR_TYPE_LSB];
		end
	end

	// Unused clock or format codes reject the whole byte so the pair stays consistent.
	assign status_ok = cap_valid
		&& targets(cap, iface_selected, xfer_type, `DFSR_TYPE_STATUS, `DFSR_REG_PRIMARY)
		&& (cap.value[`DFSR_RATIO_MSB:`DFSR_RATIO_LSB] != `DFSR_RATIO_UNUSED)
		&& (cap.value[`DFSR_IF_MSB:`DFSR_IF_LSB] <= `DFSR_IF_LAST);
	assign volume_wr = cap_valid
		&& targets(cap, iface_selected, xfer_type, `DFSR_TYPE_DATA, `DFSR_REG_PRIMARY);
	assign dm_wr = cap_valid
		&& targets(cap, iface_selected, xfer_type, `DFSR_TYPE_DATA, `DFSR_REG_SECOND);
	assign dflt_wr = cap_valid
		&& targets(cap, iface_selected, xfer_type, `DFSR_TYPE_DATA, `DFSR_REG_DEFAULT)
		&& (cap.value[`DFSR_VAL_MSB:`DFSR_VAL_LSB] == `DFSR_DEFAULT_VALUE);

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			clk_fmt.sysclk_ratio_sel <= `DFSR_RST_RATIO;
			clk_fmt.input_format <= `DFSR_RST_IF;
		end
		else if (status_ok)
		begin
			clk_fmt.sysclk_ratio_sel <= cap.value[`DFSR_RATIO_MSB:`DFSR_RATIO_LSB];
			clk_fmt.input_format <= cap.value[`DFSR_IF_MSB:`DFSR_IF_LSB];
		end
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			volume_code <= `DFSR_RST_VOLUME;
		end
		else if (volume_wr)
		begin
			volume_code <= cap.value[`DFSR_VAL_MSB:`DFSR_VAL_LSB];
		end
		else if (dflt_wr)
		begin
			volume_code <= `DFSR_RST_VOLUME;
		end
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			deemph_mute.deemph_sel <= `DFSR_RST_DEEMPH;
			deemph_mute.mute_flag <= `DFSR_RST_MUTE;
		end
		else if (dm_wr)
		begin
			deemph_mute.deemph_sel <= cap.value[`DFSR_DEEMPH_MSB:`DFSR_DEEMPH_LSB];
			deemph_mute.mute_flag <= cap.value[`DFSR_MUTE_BIT];
		end
		else if (dflt_wr)
		begin
			deemph_mute.deemph_sel <= `DFSR_RST_DEEMPH;
			deemph_mute.mute_flag <= `DFSR_RST_MUTE;
		end
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			atten_db <= `DFSR_DB_ZERO;
			full_atten <= 1'b0;
			soft_mute <= 1'b0;
		end
		else
		begin
			atten_db <= atten_of(volume_code);
			full_atten <= (volume_code > `DFSR_VOL_FINITE_END);
			soft_mute <= deemph_mute.mute_flag;
		end
	end

	a_addr_type: assert property (@(posedge clock) disable iff (sys_rst)
		cap_valid && cap.is_addr |=> xfer_type == $past(cap.value[1:0]))
		else $error("transfer type not taken from address byte");

	a_status_route: assert property (@(posedge clock) disable iff (sys_rst)
		cap_valid && !cap.is_addr && xfer_type == `DFSR_TYPE_STATUS |=> $stable(volume_code)
		&& $stable(deemph_mute))
		else $error("status byte changed a data group setting");

	a_no_partial: assert property (@(posedge clock) disable iff (sys_rst)
		!cap_valid |=> $stable(clk_fmt) && $stable(volume_code) && $stable(deemph_mute))
		else $error("setting changed without a complete byte");

	a_status_write: assert property (@(posedge clock) disable iff (sys_rst)
		status_ok |=> clk_fmt.sysclk_ratio_sel == $past(cap.value[5:4])
		&& clk_fmt.input_format == $past(cap.value[3:1]))
		else $error("status byte not stored");

	a_ratio_legal: assert property (@(posedge clock) disable iff (sys_rst)
		clk_fmt.sysclk_ratio_sel != `DFSR_RATIO_UNUSED)
		else $error("unused clock ratio code stored");

	a_format_legal: assert property (@(posedge clock) disable iff (sys_rst)
		clk_fmt.input_format <= `DFSR_IF_LAST)
		else $error("unused input format code stored");

	a_volume_write: assert property (@(posedge clock) disable iff (sys_rst)
		volume_wr |=> volume_code == $past(cap.value[5:0]) ##1 atten_db == atten_of(volume_code))
		else $error("volume byte not stored or not mapped");

	a_dm_write: assert property (@(posedge clock) disable iff (sys_rst)
		dm_wr |=> deemph_mute.deemph_sel == $past(cap.value[4:3])
		&& deemph_mute.mute_flag == $past(cap.value[2]) ##1 soft_mute == deemph_mute.mute_flag)
		else $error("de-emphasis and mute byte not stored");

	a_linear_atten: assert property (@(posedge clock) disable iff (sys_rst)
		volume_code > `DFSR_VOL_UNITY_END && volume_code <= `DFSR_VOL_LINEAR_END
		|=> atten_db == $past(volume_code) - `DFSR_VOL_STEP && !full_atten)
		else $error("lower range attenuation off by a step");

	a_mute_follow: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(deemph_mute.mute_flag) |=> soft_mute [*1])
		else $error("soft mute not applied");

	a_full_atten: assert property (@(posedge clock) disable iff (sys_rst)
		volume_code == `DFSR_VOL_FINITE_END |=> atten_db == `DFSR_DB_60 && !full_atten)
		else $error("code for -60 dB mapped wrongly");

	a_inf_atten: assert property (@(posedge clock) disable iff (sys_rst)
		volume_code > `DFSR_VOL_FINITE_END |=> full_atten)
		else $error("top volume codes not fully attenuated");

	a_unused_keep: assert property (@(posedge clock) disable iff (sys_rst)
		cap_valid && !cap.is_addr && xfer_type == `DFSR_TYPE_DATA
		&& cap.value[7:6] == 2'h1 |=> $stable(volume_code) && $stable(deemph_mute))
		else $error("unused data register changed a setting");

endmodule
`default_nettype wire

// [test/dfsr_host.sv]
// Host model that shifts bytes into the three-wire control port.
`timescale 1ns/1ps
`default_nettype none

module dfsr_host
(
	output logic ctrl_clk,
	output logic ctrl_mode,
	output logic ctrl_data,
	output logic byte_done
);
	initial
	begin
		ctrl_clk = 1'b0;
		ctrl_mode = 1'b1;
		ctrl_data = 1'b0;
		byte_done = 1'b0;
	end

	// The link clock stands still between frames, so a byte is a burst of edges.
	task automatic send_bits(input logic mode, input logic [7:0] value, input int n);
		#1.7;
		ctrl_mode = mode;
		for (int i = 7; i > 7 - n; i--)
		begin
			ctrl_data = value[i];
			#62.5 ctrl_clk = 1'b1;
			#62.5 ctrl_clk = 1'b0;
		end
		// A released data line must not keep showing the last bit.
		ctrl_data = ~ctrl_data;
		if (n == 8)
			byte_done = ~byte_done;
		#250;
	endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the DAC feature setting registers.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] %s expected %h seen %h", nm, e, g); end end

module testbench;
	import dfsr_pkg::*;
	typedef struct packed
	{
		logic [4:0] cf;
		logic [5:0] vol;
		logic [2:0] dm;
		logic [5:0] db;
		logic       full;
		logic       mute;
		logic       sel;
	} dfsr_snap_t;

	logic          clock;
	logic          sys_rst;
	wire logic     ctrl_clk;
	wire logic     ctrl_mode;
	wire logic     ctrl_data;
	wire logic     byte_done;
	dfsr_clk_fmt_t clk_fmt;
	logic [5:0]    volume_code;
	dfsr_dm_t      deemph_mute;
	logic [5:0]    atten_db;
	logic          full_atten;
	logic          soft_mute;
	logic          iface_selected;
	dfsr_snap_t    exp_s;
	dfsr_snap_t    want;
	dfsr_snap_t    notes[$];
	logic [1:0]    grp;
	int            n_errors;
	int            samples_checked;
	int unsigned   seed_ret;
	wire dfsr_snap_t got = {clk_fmt, volume_code, deemph_mute, atten_db, full_atten,
		soft_mute, iface_selected};

	dfsr_host host (.ctrl_clk(ctrl_clk), .ctrl_mode(ctrl_mode), .ctrl_data(ctrl_data),
		.byte_done(byte_done));

	dfsr_top uut (.clock(clock), .sys_rst(sys_rst), .ctrl_clk(ctrl_clk),
		.ctrl_mode(ctrl_mode), .ctrl_data(ctrl_data), .clk_fmt(clk_fmt),
		.volume_code(volume_code), .deemph_mute(deemph_mute), .atten_db(atten_db),
		.full_atten(full_atten), .soft_mute(soft_mute), .iface_selected(iface_selected));

	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	function automatic logic [5:0] to_db(input logic [5:0] c);
		if (c <= 6'h01) return 6'h00;
		if (c <= 6'h32) return c - 6'h01;
		if (c <= 6'h34) return 6'h33;
		if (c <= 6'h36) return 6'h34;
		if (c <= 6'h38) return 6'h36;
		if (c <= 6'h3A) return 6'h39;
		return 6'h3C;
	endfunction

	// The note is queued before the byte goes out, so the watcher always finds it.
	task automatic send(input logic mode, input logic [7:0] b);
		if (!mode)
		begin
			exp_s.sel = (b[7:2] == 6'h05);
			grp = b[1:0];
		end
		else if (exp_s.sel && grp == 2'h2 && b[7:6] == 2'h0 && b[5:4] != 2'h3 && b[3:1] <= 3'h4)
			exp_s.cf = b[5:1];
		else if (exp_s.sel && grp == 2'h0)
		begin
			if (b[7:6] == 2'h0) exp_s.vol = b[5:0];
			if (b[7:6] == 2'h2) exp_s.dm = b[4:2];
			if (b == 8'hC1) exp_s.vol = 6'h00;
			if (b == 8'hC1) exp_s.dm = 3'h0;
		end
		exp_s.db = to_db(exp_s.vol);
		exp_s.full = (exp_s.vol > 6'h3C);
		exp_s.mute = exp_s.dm[0];
		notes.push_back(exp_s);
		host.send_bits(mode, b, 8);
	endtask

	task automatic give_verdict;
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Settings land within six clocks of the last bit; eight clocks leaves margin.
	// Waiting for reset keeps the host's power-up level on byte_done from reading as a byte.
	initial
	begin
		@(negedge sys_rst);
		forever
		begin
			@(byte_done);
			repeat (8) @(posedge clock);
			#1;
			want = notes.pop_front();
			`CHK("settings", want, got)
		end
	end

	initial
	begin
		#400000;
		n_errors++;
		give_verdict();
	end

	initial
	begin
		n_errors = 0;
		samples_checked = 0;
		exp_s = '0;
		grp = 2'h0;
		sys_rst = 1'b1;
		seed_ret = $urandom(32'h8113);
		repeat (8) @(posedge clock);
		#1 sys_rst = 1'b0;
		repeat (4) @(posedge clock);
		`CHK("reset", 23'h0, got)
		send(1'b0, 8'h16);
		for (int i = 0; i < 32; i++)
			send(1'b1, {2'h0, i[4:0], 1'b0});
		send(1'b1, {2'h2, 6'($urandom)});
		$display("test status group done");
		send(1'b0, 8'h14);
		for (int i = 0; i < 64; i++)
			send(1'b1, {2'h0, i[5:0]});
		for (int i = 0; i < 8; i++)
			send(1'b1, {3'h4, i[2:0], 2'h0});
		$display("test data group done");
		for (int i = 0; i < 4; i++)
			send(1'b1, {2'h1, 6'($urandom)});
		send(1'b1, 8'hC5);
		send(1'b1, 8'hC1);
		$display("test unused codes done");
		host.send_bits(1'b1, 8'hFF, 3);
		send(1'b0, 8'h16);
		send(1'b1, 8'h24);
		send(1'b0, 8'h26);
		send(1'b1, 8'h0F);
		$display("test partial and deselect done");
		send(1'b0, 8'h14);
		for (int i = 0; i < 10; i++)
			send(1'b1, {1'b0, 7'($urandom)});
		$display("test random done");
		repeat (40) @(posedge clock);
		`CHK("queue", 0, notes.size())
		give_verdict();
	end
endmodule
`default_nettype wire
